// File: rtl/pbm_regs.svh
// register offsets, field positions, reset values and counts of the
// port b bus-matching block; included by the block's design file and by its bench.
`ifndef PBM_REGS_SVH
`define PBM_REGS_SVH

// ----------------------------------------------------------------------
// wishbone register map (byte addresses)
// ----------------------------------------------------------------------
`define PBM_ADDR_W 8
`define PBM_REG_CTRL 8'h00
`define PBM_REG_OFFS_ONE 8'h04
`define PBM_REG_OFFS_TWO 8'h08
`define PBM_REG_STATUS 8'h0c

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define PBM_CTRL_LOADED 0
`define PBM_OFFS_W 10
`define PBM_OFFS_FULL_LSB 0
`define PBM_OFFS_EMPTY_LSB 16
`define PBM_OFFS_DEFAULT 10'h008
`define PBM_ST_EMPTY 0
`define PBM_ST_FULL 1
`define PBM_ST_BIG 2
`define PBM_ST_WIDTH_LSB 3
`define PBM_ST_WR_IDX_LSB 5
`define PBM_ST_RD_IDX_LSB 7

// ----------------------------------------------------------------------
// lane geometry, serial chain and flag delays (cycles)
// ----------------------------------------------------------------------
`define PBM_LW 36
`define PBM_HALF_W 18
`define PBM_BYTE_W 9
`define PBM_CHAIN_W 40
`define PBM_CHAIN_LAST 6'h27
`define PBM_EMPTY_DLY_HIGH 2'h1
`define PBM_EMPTY_DLY_LOW 2'h2

// ----------------------------------------------------------------------
// synchronised pin positions
// ----------------------------------------------------------------------
`define PBM_PIN_N 9
`define PBM_PIN_MRS_AB 0
`define PBM_PIN_MRS_BA 1
`define PBM_PIN_PRS_AB 2
`define PBM_PIN_PRS_BA 3
`define PBM_PIN_ENDIAN 4
`define PBM_PIN_MATCH 5
`define PBM_PIN_SIZE 6
`define PBM_PIN_SER_IN 7
`define PBM_PIN_SER_SHIFT 8
`define PBM_PIN_RESET_VAL 9'h00f

`endif

// File: rtl/pbm_pkg.sv
// types shared by the port b bus-matching block and its bench.
// assumes nothing of its surroundings.
package pbm_pkg;

  // port b lane width in force
  typedef enum logic [1:0] {
    PBM_LONG,
    PBM_WORD,
    PBM_BYTE
  } pbm_width_e;

  // one pair of almost-full / almost-empty offsets
  typedef struct packed {
    logic [9:0] almost_full;
    logic [9:0] almost_empty;
  } pbm_offsets_s;

  // configuration seen by the lane logic
  typedef struct packed {
    pbm_width_e width;
    logic big_endian;
  } pbm_cfg_s;

endpackage : pbm_pkg

// File: rtl/pbm_port_b_bus_matching.sv
// port b bus matching: packs narrow port b writes into long words for
// the b-to-a queue and unpacks long words of the a-to-b queue.
// assumes both queue memories sit outside, on the same clock clk_i,
// with a first-word view on the read side.
`timescale 1ns/10ps
`include "pbm_regs.svh"

module pbm_port_b_bus_matching (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // device pins, asynchronous
  input wire logic master_reset_a_to_b_n_i,
  input wire logic master_reset_b_to_a_n_i,
  input wire logic partial_reset_a_to_b_n_i,
  input wire logic partial_reset_b_to_a_n_i,
  input wire logic endian_fallthrough_select_i,
  input wire logic bus_match_select_i,
  input wire logic size_select_i,
  input wire logic serial_offset_input_i,
  input wire logic serial_offset_shift_i,
  // port b transfers
  input wire logic pb_write_i,
  input wire logic pb_read_i,
  input wire logic [35:0] pb_data_i,
  output logic [35:0] pb_data_o,
  output logic port_b_empty_flag_o,
  output logic port_b_full_flag_o,
  // port a side status
  input wire logic port_a_input_ready_i,
  // b-to-a queue memory
  input wire logic ba_ready_i,
  output logic ba_push_o,
  output logic [35:0] ba_data_o,
  // a-to-b queue memory
  input wire logic ab_valid_i,
  input wire logic [35:0] ab_data_i,
  output logic ab_pop_o,
  // offsets for the flag logic
  output pbm_pkg::pbm_offsets_s offsets_one_o,
  output pbm_pkg::pbm_offsets_s offsets_two_o
);

  // --------------------------------------------------------------------
  // lane helpers
  // --------------------------------------------------------------------
  function automatic logic [1:0] last_index(input pbm_pkg::pbm_width_e w);
    case (w)
      pbm_pkg::PBM_WORD: last_index = 2'h1;
      pbm_pkg::PBM_BYTE: last_index = 2'h3;
      default: last_index = 2'h0;
    endcase
  endfunction : last_index

  // slot 0 is the least significant portion of the long word
  function automatic logic [1:0] slot_of(input pbm_pkg::pbm_cfg_s c,
                                         input logic [1:0] idx);
    slot_of = c.big_endian ? 2'(last_index(c.width) - idx) : idx;
  endfunction : slot_of

  function automatic logic [35:0] merge(input logic [35:0] aux,
                                        input logic [35:0] d,
                                        input pbm_pkg::pbm_width_e w,
                                        input logic [1:0] slot);
    merge = aux;
    case (w)
      pbm_pkg::PBM_WORD: begin
        if (slot[0]) begin
          merge[`PBM_LW-1 -: `PBM_HALF_W] = d[`PBM_HALF_W-1:0];
        end else begin
          merge[`PBM_HALF_W-1:0] = d[`PBM_HALF_W-1:0];
        end
      end
      pbm_pkg::PBM_BYTE: begin
        for (int i = 0; i < 4; i++) begin
          if (slot == 2'(i)) begin
            merge[i*`PBM_BYTE_W +: `PBM_BYTE_W] = d[`PBM_BYTE_W-1:0];
          end
        end
      end
      default: merge = d;
    endcase
  endfunction : merge

  // upper lanes read as zero in narrow modes
  function automatic logic [35:0] extract(input logic [35:0] lw,
                                          input pbm_pkg::pbm_width_e w,
                                          input logic [1:0] slot);
    extract = '0;
    case (w)
      pbm_pkg::PBM_WORD: begin
        extract[`PBM_HALF_W-1:0] = slot[0] ?
            lw[`PBM_LW-1 -: `PBM_HALF_W] : lw[`PBM_HALF_W-1:0];
      end
      pbm_pkg::PBM_BYTE: begin
        extract[`PBM_BYTE_W-1:0] =
            lw[32'(slot)*`PBM_BYTE_W +: `PBM_BYTE_W];
      end
      default: extract = lw;
    endcase
  endfunction : extract

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  logic [`PBM_PIN_N-1:0] pin_raw;
  logic [`PBM_PIN_N-1:0] pin_s1;
  logic [`PBM_PIN_N-1:0] pin_s2;
  logic [`PBM_PIN_N-1:0] pin_s3;
  logic [`PBM_PIN_N-1:0] pin;

  assign pin_raw = {serial_offset_shift_i, serial_offset_input_i,
                    size_select_i, bus_match_select_i,
                    endian_fallthrough_select_i, partial_reset_b_to_a_n_i,
                    partial_reset_a_to_b_n_i, master_reset_b_to_a_n_i,
                    master_reset_a_to_b_n_i};

  // three stages; a change counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < `PBM_PIN_N; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pin_s1[g] <= 1'(`PBM_PIN_RESET_VAL >> g);
          pin_s2[g] <= 1'(`PBM_PIN_RESET_VAL >> g);
          pin_s3[g] <= 1'(`PBM_PIN_RESET_VAL >> g);
          pin[g] <= 1'(`PBM_PIN_RESET_VAL >> g);
        end else begin
          pin_s1[g] <= pin_raw[g];
          pin_s2[g] <= pin_s1[g];
          pin_s3[g] <= pin_s2[g];
          if (pin_s2[g] == pin_s3[g]) begin
            pin[g] <= pin_s3[g];
          end
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // configuration
  // --------------------------------------------------------------------
  logic mrs_both;
  logic mrs_both_q;
  logic big_endian;
  logic wr_rst;
  logic rd_rst;
  pbm_pkg::pbm_cfg_s cfg;

  assign mrs_both = pin[`PBM_PIN_MRS_AB] & pin[`PBM_PIN_MRS_BA];
  assign wr_rst = ~pin[`PBM_PIN_MRS_BA] | ~pin[`PBM_PIN_PRS_BA];
  assign rd_rst = ~pin[`PBM_PIN_MRS_AB] | ~pin[`PBM_PIN_PRS_AB];
  // width pins are trusted static, so no capture is kept for them
  assign cfg.width = ~pin[`PBM_PIN_MATCH] ? pbm_pkg::PBM_LONG :
                     (pin[`PBM_PIN_SIZE] ? pbm_pkg::PBM_BYTE :
                      pbm_pkg::PBM_WORD);
  assign cfg.big_endian = big_endian;

  // endian caught as the master resets rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mrs_both_q <= 1'b1;
      big_endian <= 1'b0;
    end else begin
      mrs_both_q <= mrs_both;
      if (mrs_both & ~mrs_both_q) begin
        big_endian <= pin[`PBM_PIN_ENDIAN];
      end
    end
  end

  // --------------------------------------------------------------------
  // offsets: master reset preset, wishbone parallel, serial chain
  // --------------------------------------------------------------------
  logic [`PBM_CHAIN_W-1:0] chain;
  logic [5:0] chain_cnt;
  logic shift_q;
  logic shift_rise;
  logic loaded;
  logic wb_hit;
  logic [31:0] wmask;
  logic [31:0] offs_one_word;
  logic [31:0] offs_two_word;

  assign shift_rise = pin[`PBM_PIN_SER_SHIFT] & ~shift_q;
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign offs_one_word = (32'(offsets_one_o.almost_full)
                            << `PBM_OFFS_FULL_LSB) |
                         (32'(offsets_one_o.almost_empty)
                            << `PBM_OFFS_EMPTY_LSB);
  assign offs_two_word = (32'(offsets_two_o.almost_full)
                            << `PBM_OFFS_FULL_LSB) |
                         (32'(offsets_two_o.almost_empty)
                            << `PBM_OFFS_EMPTY_LSB);

  // gaps between serial bits are fine: only shift edges count
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chain <= '0;
      chain_cnt <= '0;
      shift_q <= 1'b0;
    end else begin
      shift_q <= pin[`PBM_PIN_SER_SHIFT];
      if (~mrs_both) begin
        chain_cnt <= '0;
      end else if (shift_rise & ~loaded) begin
        chain <= {chain[`PBM_CHAIN_W-2:0], pin[`PBM_PIN_SER_IN]};
        chain_cnt <= (chain_cnt == `PBM_CHAIN_LAST) ? '0 : chain_cnt + 6'h1;
      end
    end
  end

  // offset storage; one writer process for all three sources
  always_ff @(posedge clk_i) begin
    logic [31:0] nw;
    nw = '0;
    if (rst_i) begin
      offsets_one_o <= {`PBM_OFFS_DEFAULT, `PBM_OFFS_DEFAULT};
      offsets_two_o <= {`PBM_OFFS_DEFAULT, `PBM_OFFS_DEFAULT};
    end else begin
      if (~pin[`PBM_PIN_MRS_AB]) begin
        offsets_one_o <= {`PBM_OFFS_DEFAULT, `PBM_OFFS_DEFAULT};
      end
      if (~pin[`PBM_PIN_MRS_BA]) begin
        offsets_two_o <= {`PBM_OFFS_DEFAULT, `PBM_OFFS_DEFAULT};
      end
      if (mrs_both & shift_rise & ~loaded &
          chain_cnt == `PBM_CHAIN_LAST) begin
        // oldest bit sits at the top of the chain
        offsets_one_o.almost_full <= chain[38:29];
        offsets_one_o.almost_empty <= chain[28:19];
        offsets_two_o.almost_full <= chain[18:9];
        offsets_two_o.almost_empty <= {chain[8:0],
                                       pin[`PBM_PIN_SER_IN]};
      end else if (mrs_both & wb_hit & wb_we_i &
                   wb_adr_i == `PBM_REG_OFFS_ONE) begin
        nw = (offs_one_word & ~wmask) | (wb_dat_i & wmask);
        offsets_one_o.almost_full <= nw[`PBM_OFFS_FULL_LSB +: `PBM_OFFS_W];
        offsets_one_o.almost_empty <= nw[`PBM_OFFS_EMPTY_LSB +: `PBM_OFFS_W];
      end else if (mrs_both & wb_hit & wb_we_i &
                   wb_adr_i == `PBM_REG_OFFS_TWO) begin
        nw = (offs_two_word & ~wmask) | (wb_dat_i & wmask);
        offsets_two_o.almost_full <= nw[`PBM_OFFS_FULL_LSB +: `PBM_OFFS_W];
        offsets_two_o.almost_empty <= nw[`PBM_OFFS_EMPTY_LSB +: `PBM_OFFS_W];
      end
    end
  end

  // loading done: after the last serial bit or a control write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loaded <= 1'b0;
    end else if (~mrs_both) begin
      loaded <= 1'b0;
    end else if (shift_rise & chain_cnt == `PBM_CHAIN_LAST) begin
      loaded <= 1'b1;
    end else if (wb_hit & wb_we_i & wb_sel_i[0] &
                 wb_adr_i == `PBM_REG_CTRL &
                 wb_dat_i[`PBM_CTRL_LOADED]) begin
      loaded <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // write packing into the b-to-a queue
  // --------------------------------------------------------------------
  logic [1:0] wr_idx;
  logic [35:0] wr_aux;
  logic wr_last;
  logic wr_go;

  assign wr_last = (wr_idx == last_index(cfg.width));
  assign wr_go = pb_write_i & port_b_full_flag_o & ~wr_rst;

  // narrow portions wait in wr_aux; only the last one pushes
  always_ff @(posedge clk_i) begin
    if (rst_i | wr_rst) begin
      wr_idx <= '0;
      wr_aux <= '0;
      ba_push_o <= 1'b0;
      ba_data_o <= '0;
    end else begin
      ba_push_o <= wr_go & wr_last;
      if (wr_go) begin
        wr_aux <= merge(wr_aux, pb_data_i, cfg.width,
                        slot_of(cfg, wr_idx));
        wr_idx <= wr_last ? '0 : wr_idx + 2'h1;
        if (wr_last) begin
          ba_data_o <= merge(wr_aux, pb_data_i, cfg.width,
                             slot_of(cfg, wr_idx));
        end
      end
    end
  end

  // input ready; a push in flight blocks until memory status catches up
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_b_full_flag_o <= 1'b0;
    end else begin
      port_b_full_flag_o <= loaded & port_a_input_ready_i & ~wr_rst &
                            ba_ready_i & ~ba_push_o &
                            ~(wr_go & wr_last);
    end
  end

  // --------------------------------------------------------------------
  // read unpacking from the a-to-b queue
  // --------------------------------------------------------------------
  logic [1:0] rd_idx;
  logic [35:0] rd_aux;
  logic rd_last;
  logic rd_go;
  logic [1:0] rst_cnt;
  logic [1:0] empty_dly;

  assign rd_last = (rd_idx == last_index(cfg.width));
  assign rd_go = pb_read_i & port_b_empty_flag_o & ~rd_rst;
  assign ab_pop_o = rd_go & rd_last;
  assign empty_dly = pin[`PBM_PIN_ENDIAN] ? `PBM_EMPTY_DLY_HIGH :
                                            `PBM_EMPTY_DLY_LOW;

  // first portion comes from the queue head, the rest from rd_aux
  always_ff @(posedge clk_i) begin
    if (rst_i | rd_rst) begin
      rd_idx <= '0;
      rd_aux <= '0;
      pb_data_o <= '0;
    end else if (rd_go) begin
      rd_idx <= rd_last ? '0 : rd_idx + 2'h1;
      if (rd_idx == 2'h0) begin
        rd_aux <= ab_data_i;
        pb_data_o <= extract(ab_data_i, cfg.width,
                             slot_of(cfg, rd_idx));
      end else begin
        pb_data_o <= extract(rd_aux, cfg.width,
                             slot_of(cfg, rd_idx));
      end
    end
  end

  // output ready; during reset it drops after a select-dependent delay
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_cnt <= '0;
      port_b_empty_flag_o <= 1'b0;
    end else if (rd_rst) begin
      rst_cnt <= (rst_cnt == 2'h3) ? rst_cnt : rst_cnt + 2'h1;
      if (rst_cnt + 2'h1 >= empty_dly) begin
        port_b_empty_flag_o <= 1'b0;
      end
    end else begin
      rst_cnt <= '0;
      port_b_empty_flag_o <= ab_valid_i & ~ab_pop_o;
    end
  end

  // --------------------------------------------------------------------
  // wishbone answer: one wait state, unmapped reads zero
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= '0;
      if (wb_hit & ~wb_we_i) begin
        case (wb_adr_i)
          `PBM_REG_CTRL: wb_dat_o <= 32'(loaded) << `PBM_CTRL_LOADED;
          `PBM_REG_OFFS_ONE: wb_dat_o <= offs_one_word;
          `PBM_REG_OFFS_TWO: wb_dat_o <= offs_two_word;
          `PBM_REG_STATUS: begin
            wb_dat_o <= (32'(port_b_empty_flag_o) << `PBM_ST_EMPTY) |
                        (32'(port_b_full_flag_o) << `PBM_ST_FULL) |
                        (32'(big_endian) << `PBM_ST_BIG) |
                        (32'(cfg.width) << `PBM_ST_WIDTH_LSB) |
                        (32'(wr_idx) << `PBM_ST_WR_IDX_LSB) |
                        (32'(rd_idx) << `PBM_ST_RD_IDX_LSB);
          end
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

endmodule : pbm_port_b_bus_matching

// File: tb/pbm_monitor.sv
// checker of the port b bus-matching block, bound to its top ports.
// assumes one clock clk_i and a synchronous active-high rst_i.
`timescale 1ns/10ps
module pbm_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // port b
  input wire logic bus_match_select_i,
  input wire logic pb_write_i,
  input wire logic pb_read_i,
  input wire logic [35:0] pb_data_i,
  input wire logic [35:0] pb_data_o,
  input wire logic port_b_empty_flag_o,
  input wire logic port_b_full_flag_o,
  // queue memories
  input wire logic ab_valid_i,
  input wire logic [35:0] ab_data_i,
  input wire logic ab_pop_o,
  input wire logic ba_push_o,
  input wire logic [35:0] ba_data_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("request not answered next cycle");
  a_push_pulse: assert property (ba_push_o |=> !ba_push_o)
    else $error("long word pushed twice");
  a_full_gap: assert property (ba_push_o |->
    !port_b_full_flag_o ##1 !port_b_full_flag_o)
    else $error("full flag high right after commit");
  a_long_write: assert property (!bus_match_select_i && pb_write_i
    && port_b_full_flag_o |=> ba_push_o && ba_data_o == $past(pb_data_i))
    else $error("long write not pushed one-to-one");
  a_long_read: assert property (!bus_match_select_i && pb_read_i
    && port_b_empty_flag_o |-> ab_pop_o ##1 pb_data_o == $past(ab_data_i))
    else $error("long read not delivered one-to-one");
  a_pop_cause: assert property (ab_pop_o |->
    pb_read_i && port_b_empty_flag_o && ab_valid_i)
    else $error("pop without a taken read");
  a_pop_gap: assert property (ab_pop_o |=> !port_b_empty_flag_o)
    else $error("empty flag high right after pop");

  // main scenarios reached
  c_narrow_push: cover property (ba_push_o && bus_match_select_i);
  c_narrow_pop: cover property (ab_pop_o && bus_match_select_i);
  c_long_push: cover property (ba_push_o && !bus_match_select_i);
endmodule : pbm_monitor

bind pbm_port_b_bus_matching pbm_monitor pbm_monitor_i (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .bus_match_select_i, .pb_write_i,
  .pb_read_i, .pb_data_i, .pb_data_o, .port_b_empty_flag_o,
  .port_b_full_flag_o, .ab_valid_i, .ab_data_i, .ab_pop_o, .ba_push_o,
  .ba_data_o);

// File: tb/pbm_queue_model.sv
// model of the two queue memories beside the bus-matching block.
// assumes the same clock as the block; loaded by the bench.
`timescale 1ns/10ps
module pbm_queue_model (
  // clock
  input wire logic clk_i,
  // a-to-b head view
  input wire logic ab_pop_i,
  output logic ab_valid_o,
  output logic [35:0] ab_data_o,
  // b-to-a room
  input wire logic stall_i,
  output logic ba_ready_o
);
  logic [35:0] q [$];
  logic [35:0] last = 36'h0;

  initial ab_valid_o = 1'b0;
  initial ab_data_o = 36'h0;
  assign ba_ready_o = !stall_i;

  // bench side: queue one long word
  task automatic load(input logic [35:0] k);
    q.push_back(k);
  endtask : load

  // idle head shows inverted data so a stale read cannot match
  always @(posedge clk_i) begin
    if (ab_pop_i === 1'b1 && q.size() != 0) begin
      last = q.pop_front();
    end
    ab_valid_o <= (q.size() != 0);
    ab_data_o <= (q.size() != 0) ? q[0] : ~last;
  end
endmodule : pbm_queue_model

// File: tb/pbm_port_b_bus_matching_tb_top.sv
// bench of the port b bus-matching block: wishbone and port b tasks.
// assumes the queue model and the bound checker are compiled with it.
`timescale 1ns/10ps
`include "pbm_regs.svh"
module pbm_port_b_bus_matching_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, ab_valid_i, ab_pop_o, ba_ready_i, ba_push_o;
  logic master_reset_a_to_b_n_i = 1'b1;
  logic master_reset_b_to_a_n_i = 1'b1;
  logic partial_reset_a_to_b_n_i = 1'b1;
  logic partial_reset_b_to_a_n_i = 1'b1;
  logic endian_fallthrough_select_i = 1'b1;
  logic bus_match_select_i = 1'b1;
  logic size_select_i = 1'b1;
  logic serial_offset_input_i = 1'b0;
  logic serial_offset_shift_i = 1'b0;
  logic pb_write_i = 1'b0;
  logic pb_read_i = 1'b0;
  logic [35:0] pb_data_i = 36'h0;
  logic [35:0] pb_data_o, ba_data_o, ab_data_i;
  logic port_b_empty_flag_o, port_b_full_flag_o;
  logic port_a_input_ready_i = 1'b1;
  logic stall_i = 1'b0;
  pbm_pkg::pbm_offsets_s offsets_one_o, offsets_two_o;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int pushes = 0;
  localparam logic [35:0] K = 36'h9_b3c5_7e21;
  localparam logic [39:0] CHAIN = {10'h155, 10'h0aa, 10'h3c3, 10'h03c};

  pbm_port_b_bus_matching pbm_port_b_bus_matching_i (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .master_reset_a_to_b_n_i,
    .master_reset_b_to_a_n_i, .partial_reset_a_to_b_n_i,
    .partial_reset_b_to_a_n_i, .endian_fallthrough_select_i,
    .bus_match_select_i, .size_select_i, .serial_offset_input_i,
    .serial_offset_shift_i, .pb_write_i, .pb_read_i, .pb_data_i,
    .pb_data_o, .port_b_empty_flag_o, .port_b_full_flag_o,
    .port_a_input_ready_i, .ba_ready_i, .ba_push_o, .ba_data_o,
    .ab_valid_i, .ab_data_i, .ab_pop_o, .offsets_one_o, .offsets_two_o);
  pbm_queue_model pbm_queue_model_i (.clk_i, .ab_pop_i(ab_pop_o),
    .ab_valid_o(ab_valid_i), .ab_data_o(ab_data_i), .stall_i,
    .ba_ready_o(ba_ready_i));

  // ------------------------------------------------------------------
  // clock, watchdog, push counter
  // ------------------------------------------------------------------
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (ba_push_o === 1'b1) pushes <= pushes + 1;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic print_verdict();
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [35:0] got, exp, input string nm);
    total_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask : chk
  // lanes that carry a portion in each width
  function automatic logic [35:0] msk(int n);
    return n == 1 ? {36{1'b1}} : (n == 2 ? 36'h0_0003_ffff : 36'h1ff);
  endfunction : msk
  // portion i of long word k, big: top part first
  function automatic logic [35:0] part(logic [35:0] k, int n, logic big,
                                      int i);
    int j;
    j = big ? i : n - 1 - i;
    if (n == 1) return k;
    if (n == 2) return {18'h0, k[35-18*j -: 18]};
    return {27'h0, k[35-9*j -: 9]};
  endfunction : part
  // classic single cycle, released only after ack is seen
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // both master resets together, partial reset held high
  task automatic mres(input logic big, input int n);
    endian_fallthrough_select_i <= big;
    bus_match_select_i <= (n != 1);
    size_select_i <= (n == 4);
    master_reset_a_to_b_n_i <= 1'b0;
    master_reset_b_to_a_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    master_reset_a_to_b_n_i <= 1'b1;
    master_reset_b_to_a_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask : mres
  // np back-to-back portions, junk on the unused lanes
  task automatic pbw(input logic [35:0] k, input int n, input logic big,
                     input int np);
    int t;
    while (port_b_full_flag_o !== 1'b1) @(posedge clk_i);
    for (int i = 0; i < np; i++) begin
      pb_write_i <= 1'b1;
      pb_data_i <= part(k, n, big, i) | (36'hb_d5e7_a3c9 & ~msk(n));
      @(posedge clk_i);
    end
    pb_write_i <= 1'b0;
    t = 0;
    while (np == n && ba_push_o !== 1'b1 && t < 9) begin
      @(posedge clk_i);
      t++;
    end
    if (np == n) chk(ba_data_o, k, "ba_data_o");
    repeat (3) @(posedge clk_i);
  endtask : pbw
  // n back-to-back reads of one long word
  task automatic pbr(input logic [35:0] k, input int n, input logic big);
    pbm_queue_model_i.load(k);
    while (port_b_empty_flag_o !== 1'b1) @(posedge clk_i);
    pb_read_i <= 1'b1;
    for (int i = 0; i <= n; i++) begin
      if (i < n) @(posedge clk_i);
      else @(posedge clk_i);
      if (i == n - 1) pb_read_i <= 1'b0;
      if (i == n - 1) chk({35'h0, ab_pop_o}, 36'h1, "ab_pop_o");
      if (i > 0) chk(pb_data_o & msk(n), part(k, n, big, i - 1),
                     "pb_data_o");
    end
    repeat (3) @(posedge clk_i);
  endtask : pbr

  // ------------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({16'h0, offsets_one_o}, {16'h0, 20'h02008}, "offsets_one_o");
    wb(1'b0, 8'h10, 32'h0, q);
    chk({4'h0, q}, 36'h0, "unmapped read");
    mres(1'b1, 4);
    chk({16'h0, offsets_two_o}, {16'h0, 20'h02008}, "offsets_two_o");
    pb_write_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    pb_write_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(pushes, 36'h0, "pushes before loading");
    for (int i = 39; i >= 0; i--) begin
      serial_offset_input_i <= CHAIN[i];
      repeat (5) @(posedge clk_i);
      serial_offset_shift_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      serial_offset_shift_i <= 1'b0;
      repeat (5) @(posedge clk_i);
    end
    chk({16'h0, offsets_one_o}, {16'h0, CHAIN[39:20]}, "offs one");
    chk({16'h0, offsets_two_o}, {16'h0, CHAIN[19:0]}, "offs two");
    pbw(K, 4, 1'b1, 4);
    for (int b = 0; b < 2; b++) begin
      for (int j = 0; j < 3; j++) begin
        mres(b[0], 1 << j);
        wb(1'b0, `PBM_REG_STATUS, 32'h0, q);
        chk({35'h0, q[`PBM_ST_BIG]}, {35'h0, b[0]}, "big");
        chk(pushes, 36'h1 + 36'(b * 3 + j), "reset push");
        wb(1'b1, `PBM_REG_CTRL, 32'h1, q);
        pbw(K ^ 36'(j), 1 << j, b[0], 1 << j);
        pbr(~K, 1 << j, b[0]);
      end
    end
    pbw(~K, 4, 1'b1, 2);
    partial_reset_b_to_a_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    partial_reset_b_to_a_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    pbw(K, 4, 1'b1, 4);
    chk(pushes, 36'h8, "pushes after partial");
    wb(1'b1, `PBM_REG_OFFS_ONE, 32'h0015_002a, q);
    chk({16'h0, offsets_one_o}, {16'h0, 20'h0a815}, "parallel");
    stall_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk({35'h0, port_b_full_flag_o}, 36'h0, "full stalled");
    stall_i <= 1'b0;
    port_a_input_ready_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk({35'h0, port_b_full_flag_o}, 36'h0, "full a busy");
    port_a_input_ready_i <= 1'b1;
    print_verdict();
  end
endmodule : pbm_port_b_bus_matching_tb_top
